// ==== core/dmaeih_chan.v ====
// Per-half pending request, block size and transfer counters
`timescale 1ns/100ps
`include "dmaeih_defines.vh"
module dmaeih_chan (
    mclk,
    rst,
    te,
    run,
    blk,
    act,
    done,
    bsz_wr,
    cnt_wr,
    wdata,
    pend_r,
    act_clr_r,
    cpu_irq_r,
    last_r,
    bsz_r,
    cnt_r
);
    input wire mclk;
    input wire rst;
    input wire te;            // transfer_enable of this half
    input wire run;           // Half allowed to transfer
    input wire blk;           // Block transfer mode
    input wire act;           // Activating source pulse
    input wire done;          // One byte or word finished
    input wire bsz_wr;        // Software writes block size
    input wire cnt_wr;        // Software writes count
    input wire [7:0] wdata;
    output reg pend_r;        // Internal transfer request
    output reg act_clr_r;     // Activating flag cleared (pulse)
    output reg cpu_irq_r;     // Source passed to CPU (pulse)
    output reg last_r;        // Final unit done (pulse)
    output reg [7:0] bsz_r;   // Block size counter
    output reg [7:0] cnt_r;   // Transfer or block count

    reg [7:0] bsz_init_r;     // Block size as last written
    reg run_d_r;              // run one cycle ago

    // ************************************************************
    // Counters and pending request
    // ************************************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pend_r <= 1'b0;
            act_clr_r <= 1'b0;
            cpu_irq_r <= 1'b0;
            last_r <= 1'b0;
            bsz_r <= `DMAEIH_RST_BYTE;
            cnt_r <= `DMAEIH_RST_BYTE;
            bsz_init_r <= `DMAEIH_RST_BYTE;
            run_d_r <= 1'b0;
        end
        else
        begin
            act_clr_r <= 1'b0;
            cpu_irq_r <= 1'b0;
            last_r <= 1'b0;
            run_d_r <= run;
            if (act && !te)
                cpu_irq_r <= 1'b1;
            if (done && run && pend_r)
            begin
                if (blk)
                begin
                    if (bsz_r == `DMAEIH_ONE)
                    begin
                        bsz_r <= bsz_init_r;
                        pend_r <= 1'b0;
                        cnt_r <= cnt_r - `DMAEIH_ONE;
                        last_r <= (cnt_r == `DMAEIH_ONE);
                    end
                    else
                        bsz_r <= bsz_r - `DMAEIH_ONE;
                end
                else
                begin
                    pend_r <= 1'b0;
                    cnt_r <= cnt_r - `DMAEIH_ONE;
                    last_r <= (cnt_r == `DMAEIH_ONE);
                end
            end
            if (act && run)
                pend_r <= 1'b1;
            if (run_d_r && !run && blk && pend_r)
            begin
                pend_r <= 1'b0;
                act_clr_r <= 1'b1;
            end
            // Software setup of counters
            if (bsz_wr)
            begin
                bsz_r <= wdata;
                bsz_init_r <= wdata;
            end
            if (cnt_wr)
                cnt_r <= wdata;
        end
    end
endmodule

// ==== core/dmaeih_ctrl.v ====
// Top of the DMA end-interrupt, halt and resume control block
`timescale 1ns/100ps
`include "dmaeih_defines.vh"
module dmaeih_ctrl (
    mclk,
    rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    mode_16m,
    nmi,
    busy,
    act_req,
    unit_done,
    unit_half,
    ch0a_end_irq,
    ch0b_end_irq,
    ch1a_end_irq,
    ch1b_end_irq,
    end_irq_top,
    xfer_req,
    grant_valid,
    grant_half,
    mem_addr,
    io_addr,
    word_xfer,
    act_clr,
    cpu_act_irq
);
    input wire mclk;
    input wire rst;
    input wire [4:0] reg_addr;      // Half in [4:3], offset [2:0]
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;     // Valid the cycle after read
    input wire mode_16m;            // 1: 16-Mbyte, 0: 1-Mbyte
    input wire nmi;                 // Non-maskable interrupt pulse
    input wire busy;                // Datapath inside a unit
    input wire [3:0] act_req;       // Activating source pulses
    input wire unit_done;           // One byte or word finished
    input wire [1:0] unit_half;     // Half that did the unit
    output reg ch0a_end_irq;
    output reg ch0b_end_irq;
    output reg ch1a_end_irq;
    output reg ch1b_end_irq;
    output reg [1:0] end_irq_top;   // Highest pending end request
    output reg [3:0] xfer_req;      // Half wants the bus
    output reg grant_valid;         // A half is selected
    output reg [1:0] grant_half;    // Selected half
    output reg [23:0] mem_addr;     // Effective memory address
    output reg [23:0] io_addr;      // Effective I/O address
    output reg word_xfer;           // Selected half moves words
    output reg [3:0] act_clr;       // Activating flag cleared
    output reg [3:0] cpu_act_irq;   // Source forwarded to CPU

    // ************************************************************
    // Register state
    // ************************************************************
    reg [3:0] te_r;                 // transfer_enable per half
    reg [3:0] tie_r;                // end_irq_enable per half
    reg [1:0] me_r;                 // master_enable per channel
    reg [1:0] full_r;               // Full address mode per channel
    reg [3:0] blk_r;                // Block transfer mode
    reg [3:0] wsz_r;                // Word size
    reg [7:0] io_lo_r [0:3];        // io_addr_reg per half
    reg [23:0] maddr_r [0:3];       // memory_addr_reg per half
    reg nmi_wait_r;                 // NMI seen, unit still running
    reg [3:0] run;                  // Half allowed to transfer
    reg [3:0] end_nxt;              // End requests before the flop
    reg [3:0] done_h;               // unit_done split per half
    reg [3:0] upd;                  // Address update per half
    wire [3:0] pend_w;
    wire [3:0] clr_w;
    wire [3:0] cpu_w;
    wire [3:0] last_w;
    wire [31:0] bsz_w;
    wire [31:0] cnt_w;
    wire end_any;
    wire [1:0] end_idx;
    wire gnt_any;
    wire [1:0] gnt_idx;
    wire [1:0] wr_half;
    wire [2:0] wr_off;
    integer i;

    assign wr_half = reg_addr[4:3];
    assign wr_off = reg_addr[2:0];

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Memory address as driven onto the bus
    function [23:0] fn_mem;
        input [23:0] a;
        input m16;
        begin
            if (m16)
                fn_mem = a;
            else
                fn_mem = a & `DMAEIH_MASK_1M;
        end
    endfunction

    // I/O address: low byte only, page fixed at the top
    function [23:0] fn_io;
        input [7:0] b;
        input m16;
        begin
            if (m16)
                fn_io = `DMAEIH_IO_BASE_16M | {16'h0000, b};
            else
                fn_io = `DMAEIH_IO_BASE_1M | {16'h0000, b};
        end
    endfunction

    // Channel pair of a half
    function fn_pair;
        input [1:0] h;
        begin
            fn_pair = h[1];
        end
    endfunction

    // ************************************************************
    // Run enables and end requests
    // ************************************************************
    always @*
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            done_h[i] = unit_done && (unit_half == i[1:0]);
            if (i[0] == 1'b0)
            begin
                if (full_r[fn_pair(i[1:0])])
                    run[i] = te_r[i] && me_r[fn_pair(i[1:0])];
                else
                    run[i] = te_r[i];
            end
            else
            begin
                // B half is driven by its A half in full mode
                run[i] = te_r[i] && !full_r[fn_pair(i[1:0])];
            end
            // level from the two bits only
            end_nxt[i] = !te_r[i] && tie_r[i];
            // no B request in full mode
            if (i[0] == 1'b1 && full_r[fn_pair(i[1:0])])
                end_nxt[i] = 1'b0;
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            // units on a stopped half ignored
            if (i[0] == 1'b1 && full_r[fn_pair(i[1:0])])
                upd[i] = done_h[i - 1] && run[i - 1];
            else
                upd[i] = done_h[i] && run[i];
        end
    end

    // ************************************************************
    // Per-half counters and pending requests
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_ch
            dmaeih_chan u_chan (
                .mclk(mclk),
                .rst(rst),
                .te(te_r[g]),
                .run(run[g]),
                .blk(blk_r[g]),
                .act(act_req[g]),
                .done(done_h[g]),
                .bsz_wr(reg_wr && wr_half == g
                    && wr_off == `DMAEIH_OFF_BSZ),
                .cnt_wr(reg_wr && wr_half == g
                    && wr_off == `DMAEIH_OFF_CNT),
                .wdata(reg_wdata),
                .pend_r(pend_w[g]),
                .act_clr_r(clr_w[g]),
                .cpu_irq_r(cpu_w[g]),
                .last_r(last_w[g]),
                .bsz_r(bsz_w[8 * g +: 8]),
                .cnt_r(cnt_w[8 * g +: 8])
            );
        end
    endgenerate

    dmaeih_prio u_end_prio (
        .req(end_nxt),
        .any(end_any),
        .idx(end_idx)
    );

    // Same fixed order for bus grant
    dmaeih_prio u_gnt_prio (
        .req(pend_w & run),
        .any(gnt_any),
        .idx(gnt_idx)
    );

    // ************************************************************
    // Control registers, NMI halt and address update
    // ************************************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            te_r <= 4'h0;
            tie_r <= 4'h0;
            me_r <= 2'h0;
            full_r <= 2'h0;
            blk_r <= 4'h0;
            wsz_r <= 4'h0;
            nmi_wait_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
            begin
                io_lo_r[i] <= `DMAEIH_RST_BYTE;
                maddr_r[i] <= `DMAEIH_RST_ADDR;
            end
        end
        else
        begin
            // Hardware ends the transfer on the last unit
            te_r <= te_r & ~last_w;
            // NMI waits for the current unit
            if (nmi)
                nmi_wait_r <= 1'b1;
            else if (nmi_wait_r && !busy)
            begin
                me_r <= 2'h0;
                nmi_wait_r <= 1'b0;
            end
            for (i = 0; i < 4; i = i + 1)
            begin
                // Step by one byte or one word
                if (upd[i])
                    maddr_r[i] <= maddr_r[i]
                        + (wsz_r[i] ? 24'h000002 : 24'h000001);
            end
            if (reg_wr)
            begin
                case (wr_off)
                    `DMAEIH_OFF_CTRL:
                    begin
                        te_r[wr_half] <= reg_wdata[`DMAEIH_BIT_TE];
                        tie_r[wr_half] <= reg_wdata[`DMAEIH_BIT_TIE];
                        blk_r[wr_half] <= reg_wdata[`DMAEIH_BIT_BLK];
                        wsz_r[wr_half] <= reg_wdata[`DMAEIH_BIT_WORD];
                        // Pair-wide bits live in the A half only
                        if (!wr_half[0])
                        begin
                            full_r[wr_half[1]] <=
                                reg_wdata[`DMAEIH_BIT_FULL];
                            // A late NMI clear still wins
                            if (!(nmi || nmi_wait_r))
                                me_r[wr_half[1]] <=
                                    reg_wdata[`DMAEIH_BIT_ME];
                        end
                    end
                    `DMAEIH_OFF_IOLO:
                        io_lo_r[wr_half] <= reg_wdata;
                    // each address byte on its own
                    `DMAEIH_OFF_ADRE:
                        maddr_r[wr_half][23:16] <= reg_wdata;
                    `DMAEIH_OFF_ADRH:
                        maddr_r[wr_half][15:8] <= reg_wdata;
                    `DMAEIH_OFF_ADRL:
                        maddr_r[wr_half][7:0] <= reg_wdata;
                    default:
                        ;
                endcase
            end
        end
    end

    // ************************************************************
    // Register read port, data one cycle after the strobe
    // ************************************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= `DMAEIH_RST_BYTE;
        else if (reg_rd)
        begin
            case (wr_off)
                `DMAEIH_OFF_CTRL:
                    reg_rdata <= {2'b00, wsz_r[wr_half],
                        blk_r[wr_half],
                        full_r[wr_half[1]] & !wr_half[0],
                        me_r[wr_half[1]] & !wr_half[0],
                        tie_r[wr_half], te_r[wr_half]};
                `DMAEIH_OFF_IOLO:
                    reg_rdata <= io_lo_r[wr_half];
                `DMAEIH_OFF_BSZ:
                    reg_rdata <= bsz_w[8 * wr_half +: 8];
                `DMAEIH_OFF_CNT:
                    reg_rdata <= cnt_w[8 * wr_half +: 8];
                `DMAEIH_OFF_ADRE:
                    reg_rdata <= maddr_r[wr_half][23:16];
                `DMAEIH_OFF_ADRH:
                    reg_rdata <= maddr_r[wr_half][15:8];
                `DMAEIH_OFF_ADRL:
                    reg_rdata <= maddr_r[wr_half][7:0];
                // Top byte of the longword reads as zero
                default:
                    reg_rdata <= `DMAEIH_RST_BYTE;
            endcase
        end
        else
            reg_rdata <= `DMAEIH_RST_BYTE;
    end

    // ************************************************************
    // Output flops; one cycle behind the state they show
    // ************************************************************
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ch0a_end_irq <= 1'b0;
            ch0b_end_irq <= 1'b0;
            ch1a_end_irq <= 1'b0;
            ch1b_end_irq <= 1'b0;
            end_irq_top <= 2'h0;
            xfer_req <= 4'h0;
            grant_valid <= 1'b0;
            grant_half <= 2'h0;
            mem_addr <= `DMAEIH_RST_ADDR;
            io_addr <= `DMAEIH_RST_ADDR;
            word_xfer <= 1'b0;
            act_clr <= 4'h0;
            cpu_act_irq <= 4'h0;
        end
        else
        begin
            // end requests and the forwarded source pulses are the interrupts
            ch0a_end_irq <= end_nxt[0];
            ch0b_end_irq <= end_nxt[1];
            ch1a_end_irq <= end_nxt[2];
            ch1b_end_irq <= end_nxt[3];
            end_irq_top <= end_any ? end_idx : 2'h0;
            xfer_req <= pend_w & run;
            grant_valid <= gnt_any;
            grant_half <= gnt_idx;
            mem_addr <= fn_mem(maddr_r[gnt_idx], mode_16m);
            io_addr <= fn_io(io_lo_r[gnt_idx], mode_16m);
            word_xfer <= wsz_r[gnt_idx];
            act_clr <= clr_w;
            cpu_act_irq <= cpu_w;
        end
    end
endmodule

// ==== core/dmaeih_defines.vh ====
// Constants for the DMA end-interrupt and halt control block
`ifndef DMAEIH_DEFINES_VH
`define DMAEIH_DEFINES_VH
// ****************************************************************
// Register offsets inside one half (eight bytes per half)
// ****************************************************************
`define DMAEIH_OFF_CTRL 3'h0
`define DMAEIH_OFF_IOLO 3'h1
`define DMAEIH_OFF_BSZ 3'h2
`define DMAEIH_OFF_CNT 3'h3
`define DMAEIH_OFF_ADRX 3'h4
`define DMAEIH_OFF_ADRE 3'h5
`define DMAEIH_OFF_ADRH 3'h6
`define DMAEIH_OFF_ADRL 3'h7
// ****************************************************************
// Field positions in transfer_control_reg
// ****************************************************************
`define DMAEIH_BIT_TE 0
`define DMAEIH_BIT_TIE 1
`define DMAEIH_BIT_ME 2
`define DMAEIH_BIT_FULL 3
`define DMAEIH_BIT_BLK 4
`define DMAEIH_BIT_WORD 5
// ****************************************************************
// Reset values and address limits
// ****************************************************************
`define DMAEIH_RST_BYTE 8'h00
`define DMAEIH_RST_ADDR 24'h000000
`define DMAEIH_IO_BASE_1M 24'h0FFF00
`define DMAEIH_IO_BASE_16M 24'hFFFF00
`define DMAEIH_MASK_1M 24'h0FFFFF
`define DMAEIH_ONE 8'h01
`endif

// ==== core/dmaeih_prio.v ====
// Fixed priority picker: half 0 (0A) highest, half 3 (1B) lowest
`timescale 1ns/100ps
module dmaeih_prio (
    req,
    any,
    idx
);
    input wire [3:0] req;     // Requests, one per half
    output reg any;           // At least one request present
    output reg [1:0] idx;     // Winning half

    // ************************************************************
    // Channel 0 before 1, A before B
    // ************************************************************
    always @*
    begin
        any = |req;
        if (req[0])
            idx = 2'h0;
        else if (req[1])
            idx = 2'h1;
        else if (req[2])
            idx = 2'h2;
        else
            idx = 2'h3;
    end
endmodule

// ==== verif/dmaeih_ctrl_props.sv ====
// Checker on the end request, grant and address ports
`timescale 1ns/100ps
module dmaeih_props (
    input wire mclk, input wire rst,
    input wire [4:0] reg_addr, input wire [7:0] reg_wdata,
    input wire reg_wr, input wire reg_rd, input wire [7:0] reg_rdata,
    input wire mode_16m, input wire ch0a_end_irq, input wire ch0b_end_irq,
    input wire ch1a_end_irq, input wire ch1b_end_irq,
    input wire [1:0] end_irq_top, input wire [3:0] xfer_req,
    input wire grant_valid, input wire [1:0] grant_half,
    input wire [23:0] mem_addr, input wire [23:0] io_addr,
    input wire [3:0] act_clr
);
    // End lines in priority order, 0A in bit 0
    wire [3:0] ends = {ch1b_end_irq, ch1a_end_irq, ch0b_end_irq,
        ch0a_end_irq};
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ****
    // Control write to half 0, then a quiet cycle there
    // ****
    sequence s_ctl0;
        reg_wr && reg_addr == 5'h00;
    endsequence
    sequence s_quiet0;
        !(reg_wr && reg_addr == 5'h00);
    endsequence
    a_end_follows_ctrl: assert property (s_ctl0 ##1 s_quiet0 |=>
        ch0a_end_irq == (!$past(reg_wdata[0], 2) && $past(reg_wdata[1], 2)))
        else $error("end request 0A does not follow control");
    a_b_full_off: assert property (s_ctl0 ##1 s_quiet0 |=>
        !($past(reg_wdata[3], 2) && ch0b_end_irq))
        else $error("B end request raised in full mode");
    a_end_top_prio: assert property ((|ends) |->
        end_irq_top == (ends[0] ? 2'h0 : ends[1] ? 2'h1 : ends[2] ? 2'h2
        : 2'h3)) else $error("end request index not highest");
    a_grant_prio: assert property ((|xfer_req) |-> grant_valid &&
        grant_half == (xfer_req[0] ? 2'h0 : xfer_req[1] ? 2'h1
        : xfer_req[2] ? 2'h2 : 2'h3)) else $error("grant not highest");
    a_rdata_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 8'h00) else $error("read data outside its cycle");
    a_addr_1m: assert property (grant_valid && !mode_16m &&
        $stable(mode_16m) |-> mem_addr[23:20] == 4'h0)
        else $error("upper address bits used in small mode");
    a_io_window: assert property (grant_valid && $stable(mode_16m)
        |-> io_addr[23:8] == (mode_16m ? 16'hFFFF : 16'h0FFF))
        else $error("io address outside top page");
    a_clr_pulse: assert property (act_clr != 4'h0 |=>
        act_clr == 4'h0) else $error("flag clear longer than a cycle");
endmodule
bind dmaeih_ctrl dmaeih_props dmaeih_props_inst (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_16m(mode_16m),
    .ch0a_end_irq(ch0a_end_irq), .ch0b_end_irq(ch0b_end_irq),
    .ch1a_end_irq(ch1a_end_irq), .ch1b_end_irq(ch1b_end_irq),
    .end_irq_top(end_irq_top), .xfer_req(xfer_req),
    .grant_valid(grant_valid), .grant_half(grant_half),
    .mem_addr(mem_addr), .io_addr(io_addr), .act_clr(act_clr));

// ==== verif/dmaeih_ctrl_tb.sv ====
// Self-checking bench for the end request and halt control block
`timescale 1ns/100ps
module dmaeih_ctrl_tb;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, mode_16m = 0, nmi = 0;
    logic slow = 0, busy, unit_done, grant_valid, word_xfer;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    logic [3:0] act_req = 4'h0, xfer_req, act_clr, cpu_act_irq, ends;
    logic [1:0] unit_half, end_irq_top, grant_half;
    logic [23:0] mem_addr, io_addr, maddr;
    int num_errors = 0, comparisons = 0, units = 0, clrs = 0, fwds = 0;
    int ctl [4]; // Mirror of the control bytes
    int h, u0;
    dmaeih_ctrl dmaeih_ctrl_inst (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_16m(mode_16m),
        .nmi(nmi), .busy(busy), .act_req(act_req), .unit_done(unit_done),
        .unit_half(unit_half), .ch0a_end_irq(ends[0]),
        .ch0b_end_irq(ends[1]), .ch1a_end_irq(ends[2]),
        .ch1b_end_irq(ends[3]), .end_irq_top(end_irq_top),
        .xfer_req(xfer_req), .grant_valid(grant_valid),
        .grant_half(grant_half), .mem_addr(mem_addr), .io_addr(io_addr),
        .word_xfer(word_xfer), .act_clr(act_clr),
        .cpu_act_irq(cpu_act_irq));
    dmaeih_dp_model dmaeih_dp_model_inst (.mclk(mclk), .rst(rst),
        .slow(slow), .grant_valid(grant_valid), .grant_half(grant_half),
        .busy(busy), .unit_done(unit_done), .unit_half(unit_half));
    initial forever #10 mclk = ~mclk;
    // Count half 0 events; only half 0 ever transfers here
    always @(posedge mclk)
    begin
        units += unit_done;
        clrs += act_clr[0];
        fwds += cpu_act_irq[0];
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge mclk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] v);
        @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, v);
    endtask
    task automatic act0();
        @(posedge mclk) act_req <= 4'h1;
        @(posedge mclk) act_req <= 4'h0;
    endtask
    task automatic wait_units(input int n);
        for (int i = 0; i < 60 && units < n; i++)
            @(posedge mclk);
        repeat (8) @(posedge mclk);
    endtask
    // Expected end lines; a full A half silences its B partner
    function automatic logic [3:0] exp_end();
        for (int k = 0; k < 4; k++)
            exp_end[k] = !ctl[k][0] && ctl[k][1] && !(k[0] && ctl[k & 2][3]);
    endfunction
    function automatic logic [1:0] exp_top(input logic [3:0] e);
        exp_top = 2'h0;
        for (int k = 3; k >= 0; k--)
            if (e[k])
                exp_top = k[1:0];
    endfunction
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #300us;
        num_errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(96917));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // Random control bytes, master enable included
        repeat (24)
        begin
            h = $urandom % 4;
            d = $urandom;
            ctl[h] = h[0] ? d & 8'h33 : d & 8'h3F;
            wr({h[1:0], 3'h0}, d & 8'h3F);
            repeat (2) @(posedge mclk);
            #1 chk(ends, exp_end());
            chk(end_irq_top, exp_top(exp_end()));
            rd({h[1:0], 3'h0}, ctl[h]);
        end
        $display("test end lines done");
        for (h = 0; h < 4; h++)
        begin
            wr({h[1:0], 3'h0}, 8'h00);
            ctl[h] = 0;
        end
        // Address bytes, longword place read as bytes
        // Even start, since the normal test moves words
        maddr = $urandom & 24'hFFFFFE;
        mode_16m <= $urandom;
        wr(5'h01, 8'hA5);
        wr(5'h05, maddr[23:16]); // halted, memory target
        wr(5'h06, maddr[15:8]);
        wr(5'h07, maddr[7:0]);
        rd(5'h04, 8'h00);
        rd(5'h05, maddr[23:16]);
        rd(5'h07, maddr[7:0]);
        $display("test address bytes done");
        // Normal mode, two units, then the count ends it
        wr(5'h03, 8'h02);
        wr(5'h00, 8'h23); // word size
        for (int n = 0; n < 2; n++)
        begin
            u0 = units;
            act0(); // only after the last unit ended
            for (int i = 0; i < 20 && !grant_valid; i++)
                @(posedge mclk);
            #1 chk(mem_addr, (maddr + 2 * n)
                & (mode_16m ? 24'hFFFFFF : 24'h0FFFFF));
            chk(word_xfer, 1'b1);
            chk(io_addr, {mode_16m ? 16'hFFFF : 16'h0FFF, 8'hA5});
            wait_units(u0 + 1);
        end
        chk(ends[0], 1'b1);
        $display("test normal transfer done");
        // Block mode, halted by the non-maskable interrupt
        slow <= 1'b1;
        wr(5'h02, 8'h04);
        wr(5'h03, 8'h01);
        wr(5'h00, 8'h1F); // enables come with the last write
        u0 = units;
        act0();
        for (int i = 0; i < 40 && units == u0; i++)
            @(posedge mclk);
        @(posedge mclk) nmi <= 1'b1;
        @(posedge mclk) nmi <= 1'b0;
        // The unit that starts as the halt lands is dead and not counted
        h = units - u0;
        repeat (30) @(posedge mclk);
        chk(clrs, 1);
        rd(5'h02, 8'h04 - h);
        h = units;
        act0();
        repeat (12) @(posedge mclk);
        chk({xfer_req, 4'(units - h), 4'(fwds)}, 12'h000);
        wr(5'h00, 8'h1F);
        act0();
        wait_units(u0 + 5); // Four live units plus the dead one
        rd(5'h02, 8'h04);
        chk(ends[0], 1'b1);
        act0();
        repeat (4) @(posedge mclk);
        chk(fwds, 1);
        $display("test block halt done");
        close_out();
    end
endmodule

// ==== verif/dmaeih_dp_model.sv ====
// Datapath stand-in: serves each grant with one unit, prompt or slow
`timescale 1ns/100ps
module dmaeih_dp_model (
    input wire mclk, input wire rst, input wire slow,
    input wire grant_valid, input wire [1:0] grant_half,
    output logic busy, output logic unit_done, output logic [1:0] unit_half
);
    int cnt; // Unit cycles left, or idle gap when negative
    // Gap after a unit lets the dropped request settle first
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            busy <= 1'b0;
            unit_done <= 1'b0;
            unit_half <= 2'h0;
        end
        else
        begin
            unit_done <= 1'b0;
            if (cnt == 0 && grant_valid)
            begin
                busy <= 1'b1;
                unit_half <= grant_half;
                cnt <= slow ? 6 : 2;
            end
            else if (cnt == 1)
            begin
                busy <= 1'b0;
                unit_done <= 1'b1;
                cnt <= -4;
            end
            else if (cnt != 0)
            begin
                // Half index is stale after done, so scramble it
                if (cnt == -4)
                    unit_half <= ~unit_half;
                cnt <= cnt > 0 ? cnt - 1 : cnt + 1;
            end
        end
    end
endmodule
